// File: dv/sprx_src_model.sv
// frame timing and channel status source feeding the status block
`timescale 1ns/1ps

module sprx_src_model (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        run,
  input  wire logic [15:0] period,
  input  wire logic [39:0] cs_word,
  output logic             frame_tick,
  output logic             frame_edge_next,
  output logic             cs_bit,
  output logic             cs_valid,
  output logic             cs_block_start
);
  // ********************
  // frame and block counters
  // ********************
  logic [15:0] cnt_q;
  logic [7:0]  idx_q;
  logic        last;

  assign last = cnt_q >= period - 16'h1;

  // a block is 192 frames, restarted whenever the source stops
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= 16'h0;
      idx_q <= 8'h0;
    end else if (!run) begin
      cnt_q <= 16'h0;
      idx_q <= 8'h0;
    end else begin
      cnt_q <= last ? 16'h0 : cnt_q + 16'h1;
      if (last)
        idx_q <= (idx_q == 8'hbf) ? 8'h0 : idx_q + 8'h1;
    end
  end

  assign frame_edge_next = run && cnt_q == period - 16'h2;
  assign frame_tick      = run && last;
  assign cs_valid        = frame_tick;
  assign cs_block_start  = frame_tick && idx_q == 8'h0;
  // between frames the bit toggles so a stale value never looks valid
  assign cs_bit = frame_tick ? (idx_q < 8'h28 && cs_word[idx_q[5:0]]) : ~cnt_q[0];
endmodule

// File: dv/sprx_status_test.sv
// self-checking bench for the receiver status block
`timescale 1ns/1ps

module sprx_status_test;
  typedef struct {
    logic [1:0]  kind;
    logic [2:0]  sel;
    logic [39:0] val;
  } sprx_note_type;

  localparam int FP = 7, MU = 6, SEL = 5, DM = 4, GP = 3, MP = 2, OE = 1, RB = 0;

  logic        clk;
  logic        rst;
  logic        pll_lock;
  logic        parity_error;
  logic        fault_pin_function_select;
  logic        mute_release_delay_select;
  logic        nonaudio_auto_mute_enable;
  logic        osc_continuous_run;
  logic        multi_pin_direction_select;
  logic        demod_source_select;
  logic        passthrough_source_select;
  logic [1:0]  general_output_function_select;
  logic        primary_receive_input;
  logic        mp_drv;
  logic        run;
  logic [15:0] period;
  logic [39:0] cs_word;
  logic [39:0] w;
  logic [39:0] w2;
  logic [31:0] r;
  logic [31:0] seed = 32'h9a14cdf0;
  logic        fp_prev, fen_prev, mode_prev;
  int          n_errors = 0;
  int          tests_run = 0;
  int          per[10] = '{2834, 2300, 2604, 3906, 1417, 1302, 1953, 977, 709, 651};
  logic [3:0]  cod[10] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h8, 4'ha, 4'hb, 4'hd, 4'hc, 4'he};
  sprx_note_type q[$];
  sprx_note_type n;
  wire logic   frame_tick, frame_edge_next, cs_bit, cs_valid, cs_block_start;
  wire logic   fault_pin, serial_mute, recovered_clock_select, demod_data;
  wire logic   general_output_pin, multi_purpose_pin_out, multi_purpose_pin_oe;
  wire logic   fault_state_readback, multi_purpose_pin_in, mp_level;
  wire logic [3:0]  measured_rate_code;
  wire logic [39:0] received_channel_status;
  wire logic [7:0]  obits;

  // pin level: open drain low, else bench drive or pull-up
  assign mp_level = multi_purpose_pin_oe ? multi_purpose_pin_out : mp_drv;
  assign multi_purpose_pin_in = mp_level;
  assign obits = {fault_pin, serial_mute, recovered_clock_select, demod_data,
                  general_output_pin, mp_level, multi_purpose_pin_oe, fault_state_readback};

  sprx_src_model u_sprx_src_model (
    .clk, .rst, .run, .period, .cs_word, .frame_tick, .frame_edge_next, .cs_bit,
    .cs_valid, .cs_block_start
  );

  sprx_status #(.SWITCH_CYC(20), .RELEASE_CYC(30), .WIN_FRAMES(2)) u_sprx_status (
    .clk, .rst, .pll_lock, .parity_error, .frame_tick, .frame_edge_next, .cs_bit,
    .cs_valid, .cs_block_start, .fault_pin_function_select, .mute_release_delay_select,
    .nonaudio_auto_mute_enable, .osc_continuous_run, .multi_pin_direction_select,
    .demod_source_select, .passthrough_source_select, .general_output_function_select,
    .primary_receive_input, .multi_purpose_pin_in, .fault_pin, .serial_mute,
    .recovered_clock_select, .demod_data, .general_output_pin, .multi_purpose_pin_out,
    .multi_purpose_pin_oe, .measured_rate_code, .fault_state_readback,
    .received_channel_status
  );

  // ********************
  // helpers and checking
  // ********************
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask

  task automatic chk(input int s, input logic v);
    q.push_back('{2'h0, 3'(s), {39'h0, v}});
  endtask

  task automatic code_is(input logic [3:0] v);
    q.push_back('{2'h1, 3'h0, {36'h0, v}});
  endtask

  task automatic cs_is(input logic [39:0] v);
    q.push_back('{2'h2, 3'h0, v});
  endtask

  task automatic wait_ok();
    for (int i = 0; i < 40000 && fault_state_readback !== 1'b0; i++)
      @(posedge clk);
  endtask

  task automatic miss(input logic [39:0] e, input logic [39:0] g);
    n_errors++;
    $display("Error at %0t: expected %h got %h", $time, e, g);
  endtask

  task automatic cmp_bit(input logic e, input logic g);
    tests_run++;
    if (g !== e)
      miss({39'h0, e}, {39'h0, g});
  endtask

  task automatic cmp_code(input logic [3:0] e, input logic [3:0] g);
    tests_run++;
    if (g !== e)
      miss({36'h0, e}, {36'h0, g});
  endtask

  task automatic cmp_cs(input logic [39:0] e, input logic [39:0] g);
    tests_run++;
    if (g !== e)
      miss(e, g);
  endtask

  task automatic done(input string s);
    $display("test %s finished, %0d mismatches so far", s, n_errors);
  endtask

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  always @(negedge clk) begin
    while (q.size() > 0) begin
      n = q.pop_front();
      case (n.kind)
        2'h0: cmp_bit(n.val[0], obits[n.sel]);
        2'h1: cmp_code(n.val[3:0], measured_rate_code);
        default: cmp_cs(n.val, received_channel_status);
      endcase
    end
    if (fault_pin_function_select && mode_prev && fault_pin !== fp_prev)
      cmp_bit(1'b1, fen_prev);
    fp_prev = fault_pin;
    fen_prev = frame_edge_next;
    mode_prev = fault_pin_function_select;
  end

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  initial begin
    repeat (98000) @(posedge clk);
    n_errors++;
    final_report();
  end

  initial begin
    rst = 1'b1;
    pll_lock = 1'b0;
    parity_error = 1'b0;
    fault_pin_function_select = 1'b0;
    mute_release_delay_select = 1'b0;
    nonaudio_auto_mute_enable = 1'b0;
    osc_continuous_run = 1'b0;
    multi_pin_direction_select = 1'b0;
    demod_source_select = 1'b0;
    passthrough_source_select = 1'b0;
    general_output_function_select = 2'h0;
    primary_receive_input = 1'b0;
    mp_drv = 1'b1;
    run = 1'b1;
    period = 16'd2604;
    cs_word = 40'h0;
    cyc(2);
    rst <= 1'b0;
    cyc(2);
    chk(RB, 1'b1);
    chk(OE, 1'b0);
    chk(GP, 1'b0);
    chk(FP, 1'b1);
    code_is(4'h1);
    done("reset");
    for (int i = 0; i < 10; i++) begin
      pll_lock <= 1'b0;
      period <= 16'(per[i]);
      cyc(4);
      pll_lock <= 1'b1;
      if (cod[i] == 4'h1) begin
        cyc(8000);
        chk(RB, 1'b1);
      end else
        wait_ok();
      code_is(cod[i]);
    end
    period <= 16'd709;
    cyc(3000);
    code_is(4'he);
    osc_continuous_run <= 1'b1;
    cyc(5000);
    code_is(4'hc);
    done("rate");
    multi_pin_direction_select <= 1'b1; // set as input before selecting it
    for (int f = 2; f < 4; f++) begin
      general_output_function_select <= 2'(f);
      cyc(3);
      chk(GP, f[0]);
    end
    general_output_function_select <= 2'h1;
    repeat (8) begin
      r = xs();
      primary_receive_input <= r[0];
      mp_drv <= r[1];
      passthrough_source_select <= r[2];
      demod_source_select <= r[3];
      cyc(6);
      chk(GP, r[2] ? r[1] : r[0]);
      chk(DM, r[3] ? r[1] : r[0]);
    end
    done("pins");
    general_output_function_select <= 2'h0;
    multi_pin_direction_select <= 1'b0;
    mp_drv <= 1'b1;
    r = xs();
    w = {r[7:0], xs()};
    run <= 1'b0;
    period <= 16'd20;
    cs_word <= w;
    cyc(2);
    run <= 1'b1;
    cyc(3850);
    cs_is(w);
    chk(GP, w[1]);
    chk(MP, !(w[1:0] == 2'h0 && w[5:3] == 3'h1));
    w2 = {w[39:6], 3'h1, w[2], 2'h0};
    cs_word <= w2;
    cyc(1900);
    cs_is(w);
    cyc(1960);
    cs_is(w2);
    chk(GP, 1'b0);
    chk(MP, 1'b0);
    multi_pin_direction_select <= 1'b1;
    cyc(3);
    chk(OE, 1'b0);
    done("status");
    period <= 16'd2604;
    wait_ok();
    chk(FP, 1'b0);
    @(posedge frame_tick);
    cyc(1);
    parity_error <= 1'b1;
    cyc(1);
    parity_error <= 1'b0;
    cyc(2);
    chk(FP, 1'b1);
    cyc(2700);
    chk(FP, 1'b0);
    pll_lock <= 1'b0;
    cyc(10);
    chk(FP, 1'b1);
    chk(MU, 1'b1);
    chk(SEL, 1'b1);
    cyc(15);
    chk(SEL, 1'b0);
    fault_pin_function_select <= 1'b1;
    mute_release_delay_select <= 1'b1; // hold the release for an analog mute switch
    period <= 16'd24;
    pll_lock <= 1'b1;
    cyc(35);
    chk(MU, 1'b1);
    chk(FP, 1'b0);
    chk(RB, 1'b1);
    cyc(100);
    chk(MU, 1'b0);
    chk(FP, 1'b1);
    nonaudio_auto_mute_enable <= 1'b1; // armed before non-PCM data arrives
    run <= 1'b0;
    period <= 16'd20;
    cs_word <= 40'h2;
    cyc(2);
    run <= 1'b1;
    cyc(3850);
    chk(MU, 1'b1);
    chk(GP, 1'b1);
    nonaudio_auto_mute_enable <= 1'b0;
    cyc(3);
    chk(MU, 1'b0);
    done("fault");
    cyc(2);
    final_report();
  end
endmodule

// File: logic/sprx_consts.svh
// constants for the receiver status and input select block
`ifndef SPRX_CONSTS_SVH
`define SPRX_CONSTS_SVH

// ****************************************
// clock and timing
// ****************************************
`define SPRX_CLK_HZ          64'd125000000
`define SPRX_SWITCH_US       64'd2700
`define SPRX_RELEASE_MS      64'd342
`define SPRX_RATE_WIN_FRAMES 32
`define SPRX_RATE_TOL_PERMIL 35
`define SPRX_RATE_CNT_W      18

// ****************************************
// measured rate codes
// ****************************************
`define SPRX_FS_44K1  4'h0
`define SPRX_FS_BAD   4'h1
`define SPRX_FS_48K   4'h2
`define SPRX_FS_32K   4'h3
`define SPRX_FS_88K2  4'h8
`define SPRX_FS_96K   4'ha
`define SPRX_FS_64K   4'hb
`define SPRX_FS_176K4 4'hc
`define SPRX_FS_128K  4'hd
`define SPRX_FS_192K  4'he
`define SPRX_FS_RESET `SPRX_FS_BAD

// ****************************************
// channel status layout
// ****************************************
`define SPRX_CS_READ_BITS   40
`define SPRX_CS_BLOCK_LAST  8'hbf
`define SPRX_CS_PRO_BIT     0
`define SPRX_CS_NONPCM_BIT  1
`define SPRX_CS_EMPH_LSB    3
`define SPRX_CS_EMPH_5015   3'h1

`endif

// File: logic/sprx_pkg.sv
// types for the receiver status and input select block
package sprx_pkg;

  typedef enum logic [1:0] {
    SPRX_GPO_NONPCM = 2'h0,
    SPRX_GPO_THRU   = 2'h1,
    SPRX_GPO_LOW    = 2'h2,
    SPRX_GPO_HIGH   = 2'h3
  } sprx_gpo_func_type;

  typedef enum logic [2:0] {
    SPRX_MTR_IDLE  = 3'h1,
    SPRX_MTR_ARM   = 3'h2,
    SPRX_MTR_COUNT = 3'h4
  } sprx_mtr_state_type;

endpackage

// File: logic/sprx_rate_meter.sv
// crystal-clock cycle counter over a fixed number of frames
`timescale 1ns/1ps
`include "sprx_consts.svh"

module sprx_rate_meter #(
  parameter int unsigned WIN_FRAMES = `SPRX_RATE_WIN_FRAMES,
  parameter int unsigned CNT_W      = `SPRX_RATE_CNT_W
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             run,
  input  wire logic             frame_tick,
  output logic                  done,
  output logic [CNT_W-1:0]      count
);

  sprx_pkg::sprx_mtr_state_type state_q;
  sprx_pkg::sprx_mtr_state_type state_d;
  logic [CNT_W-1:0] cyc_q;
  logic [7:0]       frm_q;
  logic             win_end;
  logic             cyc_full;

  assign cyc_full = &cyc_q;
  assign win_end  = frame_tick && (frm_q == 8'(WIN_FRAMES - 1));

  // ****************************************
  // window control
  // ****************************************
  always_comb begin
    case (state_q)
      sprx_pkg::SPRX_MTR_IDLE:  state_d = run ? sprx_pkg::SPRX_MTR_ARM : sprx_pkg::SPRX_MTR_IDLE;
      sprx_pkg::SPRX_MTR_ARM:   state_d = !run ? sprx_pkg::SPRX_MTR_IDLE :
                                          frame_tick ? sprx_pkg::SPRX_MTR_COUNT :
                                          sprx_pkg::SPRX_MTR_ARM;
      sprx_pkg::SPRX_MTR_COUNT: state_d = !run ? sprx_pkg::SPRX_MTR_IDLE :
                                          win_end ? sprx_pkg::SPRX_MTR_ARM :
                                          sprx_pkg::SPRX_MTR_COUNT;
      default:                  state_d = sprx_pkg::SPRX_MTR_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= sprx_pkg::SPRX_MTR_IDLE;
      cyc_q   <= '0;
      frm_q   <= 8'h00;
      done    <= 1'b0;
      count   <= '0;
    end else begin
      state_q <= state_d;
      done    <= 1'b0;
      if (state_q != sprx_pkg::SPRX_MTR_COUNT) begin
        cyc_q <= '0;
        frm_q <= 8'h00;
      end else begin
        if (!cyc_full) begin
          cyc_q <= cyc_q + 1'b1;
        end
        if (frame_tick) begin
          frm_q <= frm_q + 8'h01;
        end
        if (win_end && run) begin
          done  <= 1'b1;
          count <= cyc_q;
        end
      end
    end
  end

endmodule

// File: logic/sprx_status.sv
// fault pin, rate measurement, channel status and input routing
//
// Overview of operation
// [R1] mute mode: fault pin shows mute, clock switch
// [R2] fault edge one clock before frame edge
// [R3] host enables delayed release for analog mute
// [R4] rate reported as fixed four-bit code
// [R5] rate measured on crystal clock from lock
// [R6] continuous oscillator keeps rate code following input
// [R7] rate outside tolerance window raises fault
// [R8] auto-stop: measure once, freeze until unlock
// [R9] readable fault bit valid in any mode
// [R10] first forty status bits readable by host
// [R11] status pins refresh once per block
// [R12] general pin non-PCM flag, multi pin emphasis
// [R13] multi pin starts released, host sets input
// [R14] demod and pass-through sources chosen independently
// [R15] function codes 10/11 drive static selector level
// [R16] flags dropped when pins serve other uses
// [R17] default: non-PCM and active-low emphasis flags
// [R18] host enables non-PCM auto mute beforehand
// [R19] default fault: lock and parity; mute: low pulse
// [R20] clock switch 2.7ms after lock change, muted
// [R21] code 00 status bit, 01 pass-through, default 00
// [R22] readback values are read-only, side-effect free
`timescale 1ns/1ps
`include "sprx_consts.svh"

module sprx_status #(
  parameter int unsigned SWITCH_CYC  = 32'((`SPRX_CLK_HZ * `SPRX_SWITCH_US) / 64'd1000000),
  parameter int unsigned RELEASE_CYC = 32'((`SPRX_CLK_HZ * `SPRX_RELEASE_MS) / 64'd1000),
  parameter int unsigned WIN_FRAMES  = `SPRX_RATE_WIN_FRAMES,
  parameter int unsigned CNT_W       = `SPRX_RATE_CNT_W
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        pll_lock,
  input  wire logic        parity_error,
  input  wire logic        frame_tick,
  input  wire logic        frame_edge_next,
  input  wire logic        cs_bit,
  input  wire logic        cs_valid,
  input  wire logic        cs_block_start,
  input  wire logic        fault_pin_function_select,
  input  wire logic        mute_release_delay_select,
  input  wire logic        nonaudio_auto_mute_enable,
  input  wire logic        osc_continuous_run,
  input  wire logic        multi_pin_direction_select,
  input  wire logic        demod_source_select,
  input  wire logic        passthrough_source_select,
  input  wire logic [1:0]  general_output_function_select,
  input  wire logic        primary_receive_input,
  input  wire logic        multi_purpose_pin_in,
  output logic             fault_pin,
  output logic             serial_mute,
  output logic             recovered_clock_select,
  output logic             demod_data,
  output logic             general_output_pin,
  output logic             multi_purpose_pin_out,
  output logic             multi_purpose_pin_oe,
  output logic [3:0]       measured_rate_code,
  output logic             fault_state_readback,
  output logic [39:0]      received_channel_status
);

  localparam int unsigned RATES = 9;
  localparam int unsigned RATE_HZ [RATES] = '{44100, 48000, 32000, 88200, 96000,
                                              64000, 176400, 128000, 192000};
  localparam logic [3:0] RATE_CODE [RATES] = '{`SPRX_FS_44K1, `SPRX_FS_48K, `SPRX_FS_32K,
                                               `SPRX_FS_88K2, `SPRX_FS_96K, `SPRX_FS_64K,
                                               `SPRX_FS_176K4, `SPRX_FS_128K, `SPRX_FS_192K};

  // ****************************************
  // rate decoding
  // ****************************************
  function automatic logic [31:0] rate_bound(input int unsigned fs, input int unsigned permil);
    logic [63:0] t;
    t = (`SPRX_CLK_HZ * 64'(WIN_FRAMES) * 64'(permil)) / (64'(fs) * 64'd1000);
    return t[31:0];
  endfunction

  function automatic logic [3:0] rate_classify(input logic [CNT_W-1:0] cnt);
    logic [3:0] code;
    code = `SPRX_FS_BAD;
    for (int i = 0; i < RATES; i++) begin
      if (32'(cnt) >= rate_bound(RATE_HZ[i], 1000 - `SPRX_RATE_TOL_PERMIL) &&
          32'(cnt) <= rate_bound(RATE_HZ[i], 1000 + `SPRX_RATE_TOL_PERMIL)) begin
        code = RATE_CODE[i];
      end
    end
    return code;
  endfunction

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [1:0] rx_sync_q;
  logic [1:0] mp_sync_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_sync_q <= 2'h0;
      mp_sync_q <= 2'h0;
    end else begin
      rx_sync_q <= {rx_sync_q[0], primary_receive_input};
      mp_sync_q <= {mp_sync_q[0], multi_purpose_pin_in};
    end
  end

  // ****************************************
  // clock switch timing
  // ****************************************
  logic        lock_prev_q;
  logic        switch_busy_q;
  logic [31:0] switch_cnt_q;
  logic        lock_change;

  assign lock_change = pll_lock != lock_prev_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lock_prev_q            <= 1'b0;
      switch_busy_q          <= 1'b0;
      switch_cnt_q           <= 32'h0;
      recovered_clock_select <= 1'b0;
    end else begin
      lock_prev_q <= pll_lock;
      if (lock_change) begin                               // [R20]
        switch_busy_q <= 1'b1;
        switch_cnt_q  <= 32'(SWITCH_CYC - 1);
      end else if (switch_busy_q) begin
        if (switch_cnt_q == 32'h0) begin
          switch_busy_q          <= 1'b0;
          recovered_clock_select <= pll_lock;              // [R20]
        end else begin
          switch_cnt_q <= switch_cnt_q - 32'h1;
        end
      end
    end
  end

  // ****************************************
  // sample rate measurement
  // ****************************************
  logic             mtr_run;
  logic             mtr_done;
  logic [CNT_W-1:0] mtr_count;
  logic [3:0]       rate_new;
  logic             rate_seen_q;
  logic             rate_frozen_q;
  logic             rate_bad_q;

  assign mtr_run  = pll_lock && (osc_continuous_run || !rate_frozen_q);  // [R5] [R6] [R8]
  assign rate_new = rate_classify(mtr_count);                            // [R4]

  sprx_rate_meter #(
    .WIN_FRAMES (WIN_FRAMES),
    .CNT_W      (CNT_W)
  ) u_meter (
    .clk        (clk),
    .rst        (rst),
    .run        (mtr_run),
    .frame_tick (frame_tick),
    .done       (mtr_done),
    .count      (mtr_count)
  );

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      measured_rate_code <= `SPRX_FS_RESET;
      rate_seen_q        <= 1'b0;
      rate_frozen_q      <= 1'b0;
      rate_bad_q         <= 1'b0;
    end else begin
      if (!pll_lock) begin
        rate_seen_q   <= 1'b0;
        rate_frozen_q <= 1'b0;                             // [R8]
      end else if (mtr_done && mtr_run) begin
        measured_rate_code <= rate_new;                    // [R5]
        rate_seen_q        <= 1'b1;
        rate_frozen_q      <= !osc_continuous_run;         // [R8]
        rate_bad_q         <= rate_new == `SPRX_FS_BAD;    // [R7]
      end
    end
  end

  // ****************************************
  // channel status capture
  // ****************************************
  logic [7:0]  cs_idx_q;
  logic [7:0]  cs_idx_d;
  logic [39:0] cs_shadow_q;
  logic        block_end;
  logic        nonaudio_flag_q;
  logic        emph_flag_q;
  logic        cs_ready_q;
  logic        emph_now;

  assign cs_idx_d  = cs_block_start ? 8'h00 : cs_idx_q + 8'h01;
  assign block_end = cs_valid && cs_idx_d == `SPRX_CS_BLOCK_LAST;
  assign emph_now  = !cs_shadow_q[`SPRX_CS_PRO_BIT] && !cs_shadow_q[`SPRX_CS_NONPCM_BIT] &&
                     cs_shadow_q[`SPRX_CS_EMPH_LSB +: 3] == `SPRX_CS_EMPH_5015;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cs_idx_q                <= 8'h00;
      cs_shadow_q             <= 40'h0;
      received_channel_status <= 40'h0;
      nonaudio_flag_q         <= 1'b0;
      emph_flag_q             <= 1'b0;
      cs_ready_q              <= 1'b0;
    end else if (cs_valid) begin
      cs_idx_q <= cs_idx_d;
      if (cs_idx_d < 8'(`SPRX_CS_READ_BITS)) begin
        cs_shadow_q[cs_idx_d[5:0]] <= cs_bit;
      end
      if (block_end) begin
        received_channel_status <= cs_shadow_q;                       // [R10] [R22]
        nonaudio_flag_q         <= cs_shadow_q[`SPRX_CS_NONPCM_BIT];  // [R11]
        emph_flag_q             <= emph_now;                          // [R11]
        cs_ready_q              <= 1'b1;
      end
    end
  end

  // ****************************************
  // fault and mute
  // ****************************************
  logic        parity_hold_q;
  logic        busy_prev_q;
  logic [31:0] hold_cnt_q;
  logic        err_now;
  logic        mute_now;

  assign err_now  = !pll_lock || parity_hold_q || switch_busy_q || rate_bad_q ||
                    (pll_lock && !rate_seen_q);                              // [R7] [R19] [R20]
  assign mute_now = switch_busy_q || hold_cnt_q != 32'h0 ||
                    (busy_prev_q && mute_release_delay_select) ||
                    (nonaudio_auto_mute_enable && nonaudio_flag_q);          // [R1]

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      parity_hold_q        <= 1'b0;
      busy_prev_q          <= 1'b0;
      hold_cnt_q           <= 32'h0;
      serial_mute          <= 1'b1;
      fault_pin            <= 1'b1;
      fault_state_readback <= 1'b1;
    end else begin
      parity_hold_q <= parity_error || (parity_hold_q && !frame_tick);
      busy_prev_q   <= switch_busy_q;
      if (switch_busy_q) begin
        hold_cnt_q <= 32'h0;
      end else if (busy_prev_q && mute_release_delay_select) begin
        hold_cnt_q <= 32'(RELEASE_CYC);
      end else if (hold_cnt_q != 32'h0) begin
        hold_cnt_q <= hold_cnt_q - 32'h1;
      end
      serial_mute          <= mute_now;
      fault_state_readback <= err_now;                     // [R9]
      if (!fault_pin_function_select) begin
        fault_pin <= err_now;                              // [R19]
      end else if (frame_edge_next) begin
        fault_pin <= !mute_now;                            // [R1] [R2]
      end
    end
  end

  // ****************************************
  // input routing and flag pins
  // ****************************************
  logic gpo_d;
  logic thru_data;

  assign thru_data = passthrough_source_select ? mp_sync_q[1] : rx_sync_q[1];  // [R14]

  always_comb begin
    case (general_output_function_select)
      sprx_pkg::SPRX_GPO_NONPCM: gpo_d = nonaudio_flag_q;  // [R12] [R17] [R21]
      sprx_pkg::SPRX_GPO_THRU:   gpo_d = thru_data;        // [R16] [R21]
      sprx_pkg::SPRX_GPO_LOW:    gpo_d = 1'b0;             // [R15]
      sprx_pkg::SPRX_GPO_HIGH:   gpo_d = 1'b1;             // [R15]
      default:                   gpo_d = 1'b0;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      demod_data            <= 1'b0;
      general_output_pin    <= 1'b0;
      multi_purpose_pin_out <= 1'b0;
      multi_purpose_pin_oe  <= 1'b0;                       // [R13]
    end else begin
      demod_data            <= demod_source_select ? mp_sync_q[1] : rx_sync_q[1];  // [R14]
      general_output_pin    <= gpo_d;
      multi_purpose_pin_out <= 1'b0;
      multi_purpose_pin_oe  <= !multi_pin_direction_select && cs_ready_q &&
                               emph_flag_q;                // [R12] [R16] [R17]
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  rate_code_legal_a: assert property (measured_rate_code inside {`SPRX_FS_44K1, `SPRX_FS_BAD,
      `SPRX_FS_48K, `SPRX_FS_32K, `SPRX_FS_88K2, `SPRX_FS_96K, `SPRX_FS_64K, `SPRX_FS_176K4,
      `SPRX_FS_128K, `SPRX_FS_192K})
    else $error("illegal rate code");  // [R4]
  fault_edge_align_a: assert property (fault_pin_function_select &&
      $past(fault_pin_function_select) && $changed(fault_pin) |-> $past(frame_edge_next))
    else $error("fault pin moved off frame edge");  // [R2]
  mute_low_pulse_a: assert property ($past(fault_pin_function_select) &&
      $past(frame_edge_next) && $past(switch_busy_q) |-> !fault_pin)
    else $error("fault pin not low during mute");  // [R1]
  switch_fault_high_a: assert property ($past(!fault_pin_function_select) &&
      $past(switch_busy_q) |-> fault_pin)
    else $error("fault pin low during clock switch");  // [R20]
  readback_error_a: assert property ($past(!pll_lock) |-> fault_state_readback)
    else $error("readback clear while unlocked");  // [R9]
  gpo_static_a: assert property ($past(general_output_function_select[1]) |->
      general_output_pin == $past(general_output_function_select[0]))
    else $error("selector level wrong");  // [R15]
  gpo_flag_a: assert property ($past(general_output_function_select) == 2'h0 |->
      general_output_pin == $past(nonaudio_flag_q))
    else $error("non-PCM flag not on general pin");  // [R21]
  rate_frozen_a: assert property (!osc_continuous_run && pll_lock && rate_frozen_q |=>
      $stable(measured_rate_code))
    else $error("frozen rate code changed");  // [R8]
  mp_input_float_a: assert property ($past(multi_pin_direction_select) |->
      !multi_purpose_pin_oe)
    else $error("multi pin driven while input");  // [R16]
  cs_block_update_a: assert property ($changed(received_channel_status) |->
      $past(block_end))
    else $error("status changed outside block end");  // [R11]
  switch_length_a: assert property ($rose(switch_busy_q) && !lock_change |=>
      switch_busy_q [*8])
    else $error("clock switch ended early");  // [R20]

endmodule
